//--- hdl/stpm_pkg.sv
// constants for the serial/timer/remote pin multiplexer
package stpm_pkg;
  localparam int unsigned NPORT    = 4;
  localparam int unsigned NTIMER   = 4;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_DIR     = 8'h00;
  localparam logic [7:0] OFS_PU      = 8'h10;
  localparam logic [7:0] OFS_DAT     = 8'h20;
  localparam logic [7:0] OFS_OD      = 8'h30;
  localparam logic [7:0] OFS_P1SEL   = 8'h40;
  localparam logic [7:0] OFS_SIO0MD  = 8'h44;
  localparam logic [7:0] OFS_SIO1MD  = 8'h48;
  localparam logic [7:0] OFS_SIO3MD  = 8'h4C;
  localparam logic [7:0] OFS_SIO4CTL = 8'h50;
  localparam logic [7:0] OFS_RMCTL   = 8'h54;
  localparam logic [7:0] OFS_PINS    = 8'h58;
  // port slots inside the per-port groups
  localparam int unsigned PX0 = 0;
  localparam int unsigned PX1 = 1;
  localparam int unsigned PX5 = 2;
  localparam int unsigned PX7 = 3;
  // mode register one fields
  localparam int unsigned MD_TX     = 0;
  localparam int unsigned MD_RX     = 1;
  localparam int unsigned MD_CLKMST = 2;
  localparam int unsigned MD_UART   = 3;
  localparam int unsigned SIO4_EN   = 0;
  localparam int unsigned RM_CARR   = 0;
  // pin positions
  localparam int unsigned B_SIO1_TX  = 0;
  localparam int unsigned B_SIO1_RX  = 1;
  localparam int unsigned B_SIO1_CLK = 2;
  localparam int unsigned B_SIO0_TX  = 3;
  localparam int unsigned B_SIO0_RX  = 4;
  localparam int unsigned B_SIO0_CLK = 5;
  localparam int unsigned B_SIO4_DAT = 1;
  localparam int unsigned B_SIO4_CLK = 2;
  localparam int unsigned B_SIO3_RX  = 0;
  localparam int unsigned B_SIO3_TX  = 1;
  localparam int unsigned B_SIO3_CLK = 2;
  localparam logic [7:0]  RST_REG    = 8'h00;
  localparam logic [31:0] RST_WORD   = 32'h00000000;
endpackage : stpm_pkg

//--- hdl/stpm_top.sv
// pin multiplexer for serial interfaces 0/1/3/4, 8-bit timers and remote carrier
// How it works
// R1: every serial transmit and clock pin can be set to push-pull or open-drain drive.
// R2: a serial transmit pin carries serial data only with direction output and transmit mode set.
// R3: a serial pin whose interface is idle works as a plain port bit.
// R4: a receive pin feeds the interface when direction is input and receive mode is set.
// R5: a clock pin drives or receives the clock as direction and master mode choose.
// R6: in UART mode interfaces 0 and 1 put the UART transmit stream on their transmit pin.
// R7: in UART mode interfaces 0 and 1 take the receive pin level into the UART receiver.
// R8: the interface 4 data and clock pins are forced to open-drain drive while it is enabled.
// R9: software keeps the interface 4 pins set to output during communication.
// R10: a timer pin set as input supplies the timer event clock.
// R11: a timer pin outputs the timer signal only with special function and output direction.
// R12: a timer pin used as input gets its pull-up when the pull-up bit enables it.
// R13: each serial clock pin has a software enabled pull-up.
// R14: the remote pin sends the carrier signal with special function, output and carrier enabled.
// R15: the remote carrier control register chooses plain timer or carrier output.
// R16: with no function selected a pin follows its port data, direction and open-drain bits only.
`timescale 1ns/10ps
module stpm_top #(
  parameter int unsigned AW = 12
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic [7:0]    port0_pin_in,
  input  wire logic [7:0]    port1_pin_in,
  input  wire logic [7:0]    port5_pin_in,
  input  wire logic [7:0]    port7_pin_in,
  output logic [7:0]         port0_pin_out,
  output logic [7:0]         port1_pin_out,
  output logic [7:0]         port5_pin_out,
  output logic [7:0]         port7_pin_out,
  output logic [7:0]         port0_pin_oe,
  output logic [7:0]         port1_pin_oe,
  output logic [7:0]         port5_pin_oe,
  output logic [7:0]         port7_pin_oe,
  output logic [7:0]         port0_pullup_en,
  output logic [7:0]         port1_pullup_en,
  output logic [7:0]         port5_pullup_en,
  output logic [7:0]         port7_pullup_en,
  input  wire logic          sio0_txd,
  input  wire logic          uart0_txd,
  input  wire logic          sio0_clk_out,
  input  wire logic          sio1_txd,
  input  wire logic          uart1_txd,
  input  wire logic          sio1_clk_out,
  input  wire logic          sio3_txd,
  input  wire logic          sio3_clk_out,
  input  wire logic          sio4_data_out,
  input  wire logic          sio4_clock_out,
  input  wire logic [3:0]    timer_out,
  input  wire logic          remote_carrier,
  output logic               sio0_rxd,
  output logic               sio0_clk_in,
  output logic               sio1_rxd,
  output logic               sio1_clk_in,
  output logic               sio3_rxd,
  output logic               sio3_clk_in,
  output logic               sio4_data_in,
  output logic               sio4_clock_in,
  output logic [3:0]         timer_event
);

  logic [7:0]  dir_ff   [stpm_pkg::NPORT];
  logic [7:0]  pu_ff    [stpm_pkg::NPORT];
  logic [7:0]  dat_ff   [stpm_pkg::NPORT];
  logic [7:0]  od_ff    [stpm_pkg::NPORT];
  logic [7:0]  sync1_ff [stpm_pkg::NPORT];
  logic [7:0]  sync2_ff [stpm_pkg::NPORT];
  logic [7:0]  drv      [stpm_pkg::NPORT];
  logic [7:0]  val      [stpm_pkg::NPORT];
  logic [7:0]  odm      [stpm_pkg::NPORT];
  logic [7:0]  nxt_out  [stpm_pkg::NPORT];
  logic [7:0]  nxt_oe   [stpm_pkg::NPORT];
  logic [7:0]  nxt_pu   [stpm_pkg::NPORT];
  logic [7:0]  pin_in   [stpm_pkg::NPORT];
  logic [7:0]  p1sel_ff;
  logic [7:0]  md0_ff;
  logic [7:0]  md1_ff;
  logic [7:0]  md3_ff;
  logic [7:0]  sio4_ff;
  logic [7:0]  rm_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        nxt_err;
  logic [31:0] nxt_rdata;
  logic        wr_en;
  logic [7:0]  per_ff;
  logic [7:0]  nxt_per;
  logic [3:0]  tev_ff;
  logic [3:0]  nxt_tev;

  // clock pin is only meaningful for a synchronous, active interface
  function automatic logic clk_used(input logic [7:0] md);
    clk_used = (md[stpm_pkg::MD_TX] | md[stpm_pkg::MD_RX]) & ~md[stpm_pkg::MD_UART];
  endfunction : clk_used

  // open-drain only ever pulls low; a high is left to the pull-up
  function automatic logic [1:0] drive_stage(input logic d, input logic v, input logic o);
    drive_stage = o ? {d & ~v, 1'b0} : {d, v};
  endfunction : drive_stage

  assign pin_in[stpm_pkg::PX0] = port0_pin_in;
  assign pin_in[stpm_pkg::PX1] = port1_pin_in;
  assign pin_in[stpm_pkg::PX5] = port5_pin_in;
  assign pin_in[stpm_pkg::PX7] = port7_pin_in;
  assign wr_en = psel & penable & pready_ff & pwrite;

  // pins come from outside, two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    for (int p = 0; p < stpm_pkg::NPORT; p++)
    begin
      if (!presetn)
      begin
        sync1_ff[p] <= stpm_pkg::RST_REG;
        sync2_ff[p] <= stpm_pkg::RST_REG;
      end
      else
      begin
        sync1_ff[p] <= pin_in[p];
        sync2_ff[p] <= sync1_ff[p];
      end
    end
  end

  // per-port configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    for (int p = 0; p < stpm_pkg::NPORT; p++)
    begin
      if (!presetn)
      begin
        dir_ff[p] <= stpm_pkg::RST_REG;
        pu_ff[p]  <= stpm_pkg::RST_REG;
        dat_ff[p] <= stpm_pkg::RST_REG;
        od_ff[p]  <= stpm_pkg::RST_REG;
      end
      else if (wr_en && paddr[AW-1:8] == '0 && paddr[1:0] == 2'b00 && paddr[3:2] == 2'(p))
      begin
        if (paddr[7:4] == stpm_pkg::OFS_DIR[7:4])
          dir_ff[p] <= pwdata[7:0];
        else if (paddr[7:4] == stpm_pkg::OFS_PU[7:4])
          pu_ff[p] <= pwdata[7:0];
        else if (paddr[7:4] == stpm_pkg::OFS_DAT[7:4])
          dat_ff[p] <= pwdata[7:0];
        else if (paddr[7:4] == stpm_pkg::OFS_OD[7:4])
          od_ff[p] <= pwdata[7:0]; // see R1
      end
    end
  end

  // function select registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p1sel_ff <= stpm_pkg::RST_REG;
      md0_ff   <= stpm_pkg::RST_REG;
      md1_ff   <= stpm_pkg::RST_REG;
      md3_ff   <= stpm_pkg::RST_REG;
      sio4_ff  <= stpm_pkg::RST_REG;
      rm_ff    <= stpm_pkg::RST_REG;
    end
    else if (wr_en && paddr[AW-1:8] == '0)
    begin
      if (paddr[7:0] == stpm_pkg::OFS_P1SEL)
        p1sel_ff <= pwdata[7:0];
      else if (paddr[7:0] == stpm_pkg::OFS_SIO0MD)
        md0_ff <= pwdata[7:0];
      else if (paddr[7:0] == stpm_pkg::OFS_SIO1MD)
        md1_ff <= pwdata[7:0];
      else if (paddr[7:0] == stpm_pkg::OFS_SIO3MD)
        md3_ff <= pwdata[7:0];
      else if (paddr[7:0] == stpm_pkg::OFS_SIO4CTL)
        sio4_ff <= pwdata[7:0];
      else if (paddr[7:0] == stpm_pkg::OFS_RMCTL)
        rm_ff <= pwdata[7:0]; // see R15
    end
  end

  // read mux and unmapped detection
  always_comb
  begin
    nxt_rdata = stpm_pkg::RST_WORD;
    nxt_err   = 1'b0;
    if (paddr[AW-1:8] != '0 || paddr[1:0] != 2'b00)
      nxt_err = 1'b1;
    else if (paddr[7:4] == stpm_pkg::OFS_DIR[7:4])
      nxt_rdata[7:0] = dir_ff[paddr[3:2]];
    else if (paddr[7:4] == stpm_pkg::OFS_PU[7:4])
      nxt_rdata[7:0] = pu_ff[paddr[3:2]];
    else if (paddr[7:4] == stpm_pkg::OFS_DAT[7:4])
      nxt_rdata[7:0] = dat_ff[paddr[3:2]];
    else if (paddr[7:4] == stpm_pkg::OFS_OD[7:4])
      nxt_rdata[7:0] = od_ff[paddr[3:2]];
    else if (paddr[7:0] == stpm_pkg::OFS_P1SEL)
      nxt_rdata[7:0] = p1sel_ff;
    else if (paddr[7:0] == stpm_pkg::OFS_SIO0MD)
      nxt_rdata[7:0] = md0_ff;
    else if (paddr[7:0] == stpm_pkg::OFS_SIO1MD)
      nxt_rdata[7:0] = md1_ff;
    else if (paddr[7:0] == stpm_pkg::OFS_SIO3MD)
      nxt_rdata[7:0] = md3_ff;
    else if (paddr[7:0] == stpm_pkg::OFS_SIO4CTL)
      nxt_rdata[7:0] = sio4_ff;
    else if (paddr[7:0] == stpm_pkg::OFS_RMCTL)
      nxt_rdata[7:0] = rm_ff;
    else if (paddr[7:0] == stpm_pkg::OFS_PINS)
      nxt_rdata = {sync2_ff[3], sync2_ff[2], sync2_ff[1], sync2_ff[0]};
    else
      nxt_err = 1'b1;
  end

  // one wait-free access phase: ready follows every setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= stpm_pkg::RST_WORD;
    end
    else
    begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= psel & ~penable & nxt_err;
      if (psel && !penable && !pwrite)
        prdata_ff <= nxt_rdata;
    end
  end

  // pin routing; later assignments take priority
  always_comb
  begin
    for (int p = 0; p < stpm_pkg::NPORT; p++)
    begin
      drv[p] = dir_ff[p]; // see R3, R16
      val[p] = dat_ff[p];
      odm[p] = od_ff[p];
    end
    if (md0_ff[stpm_pkg::MD_TX] && dir_ff[0][stpm_pkg::B_SIO0_TX]) // see R2
      val[0][stpm_pkg::B_SIO0_TX] = md0_ff[stpm_pkg::MD_UART] ? uart0_txd : sio0_txd; // see R6
    if (clk_used(md0_ff)) // see R5
    begin
      drv[0][stpm_pkg::B_SIO0_CLK] = dir_ff[0][stpm_pkg::B_SIO0_CLK] & md0_ff[stpm_pkg::MD_CLKMST];
      val[0][stpm_pkg::B_SIO0_CLK] = sio0_clk_out;
    end
    if (md1_ff[stpm_pkg::MD_TX] && dir_ff[0][stpm_pkg::B_SIO1_TX]) // see R2
      val[0][stpm_pkg::B_SIO1_TX] = md1_ff[stpm_pkg::MD_UART] ? uart1_txd : sio1_txd; // see R6
    if (clk_used(md1_ff)) // see R5
    begin
      drv[0][stpm_pkg::B_SIO1_CLK] = dir_ff[0][stpm_pkg::B_SIO1_CLK] & md1_ff[stpm_pkg::MD_CLKMST];
      val[0][stpm_pkg::B_SIO1_CLK] = sio1_clk_out;
    end
    if (md3_ff[stpm_pkg::MD_TX] && dir_ff[2][stpm_pkg::B_SIO3_TX]) // see R2
      val[2][stpm_pkg::B_SIO3_TX] = sio3_txd;
    if (clk_used(md3_ff)) // see R5
    begin
      drv[2][stpm_pkg::B_SIO3_CLK] = dir_ff[2][stpm_pkg::B_SIO3_CLK] & md3_ff[stpm_pkg::MD_CLKMST];
      val[2][stpm_pkg::B_SIO3_CLK] = sio3_clk_out;
    end
    // interface 4 shares interface 1 receive/clock pins and overrides their output value and open-drain mode
    if (sio4_ff[stpm_pkg::SIO4_EN])
    begin
      val[0][stpm_pkg::B_SIO4_DAT] = sio4_data_out;
      val[0][stpm_pkg::B_SIO4_CLK] = sio4_clock_out;
      odm[0][stpm_pkg::B_SIO4_DAT] = 1'b1; // see R8
      odm[0][stpm_pkg::B_SIO4_CLK] = 1'b1; // see R8
    end
    for (int t = 0; t < stpm_pkg::NTIMER; t++)
    begin
      if (p1sel_ff[t] && dir_ff[1][t]) // see R11
        val[1][t] = timer_out[t];
    end
    if (p1sel_ff[0] && dir_ff[1][0] && rm_ff[stpm_pkg::RM_CARR]) // see R14, R15
      val[1][0] = timer_out[0] & remote_carrier;
    for (int p = 0; p < stpm_pkg::NPORT; p++)
    begin
      for (int b = 0; b < 8; b++)
        {nxt_oe[p][b], nxt_out[p][b]} = drive_stage(drv[p][b], val[p][b], odm[p][b]); // see R1
      nxt_pu[p] = pu_ff[p] & ~drv[p]; // see R12, R13
    end
  end

  // receive-side routing; idle level high for serial, low for timers
  always_comb
  begin
    nxt_per    = 8'hFF;
    if (md0_ff[stpm_pkg::MD_RX] && !dir_ff[0][stpm_pkg::B_SIO0_RX]) // see R4, R7
      nxt_per[0] = sync2_ff[0][stpm_pkg::B_SIO0_RX];
    if (clk_used(md0_ff) && !drv[0][stpm_pkg::B_SIO0_CLK]) // see R5
      nxt_per[1] = sync2_ff[0][stpm_pkg::B_SIO0_CLK];
    if (md1_ff[stpm_pkg::MD_RX] && !dir_ff[0][stpm_pkg::B_SIO1_RX]) // see R4, R7
      nxt_per[2] = sync2_ff[0][stpm_pkg::B_SIO1_RX];
    if (clk_used(md1_ff) && !drv[0][stpm_pkg::B_SIO1_CLK]) // see R5
      nxt_per[3] = sync2_ff[0][stpm_pkg::B_SIO1_CLK];
    if (md3_ff[stpm_pkg::MD_RX] && !dir_ff[2][stpm_pkg::B_SIO3_RX]) // see R4
      nxt_per[4] = sync2_ff[2][stpm_pkg::B_SIO3_RX];
    if (clk_used(md3_ff) && !drv[2][stpm_pkg::B_SIO3_CLK]) // see R5
      nxt_per[5] = sync2_ff[2][stpm_pkg::B_SIO3_CLK];
    if (sio4_ff[stpm_pkg::SIO4_EN])
    begin
      nxt_per[6] = sync2_ff[0][stpm_pkg::B_SIO4_DAT];
      nxt_per[7] = sync2_ff[0][stpm_pkg::B_SIO4_CLK];
    end
    nxt_tev = sync2_ff[1][3:0] & ~dir_ff[1][3:0]; // see R10
  end

  // all pin and peripheral outputs are registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port0_pin_out <= stpm_pkg::RST_REG;
      port1_pin_out <= stpm_pkg::RST_REG;
      port5_pin_out <= stpm_pkg::RST_REG;
      port7_pin_out <= stpm_pkg::RST_REG;
      port0_pin_oe  <= stpm_pkg::RST_REG;
      port1_pin_oe  <= stpm_pkg::RST_REG;
      port5_pin_oe  <= stpm_pkg::RST_REG;
      port7_pin_oe  <= stpm_pkg::RST_REG;
      port0_pullup_en <= stpm_pkg::RST_REG;
      port1_pullup_en <= stpm_pkg::RST_REG;
      port5_pullup_en <= stpm_pkg::RST_REG;
      port7_pullup_en <= stpm_pkg::RST_REG;
      per_ff <= 8'hFF;
      tev_ff <= 4'h0;
    end
    else
    begin
      port0_pin_out <= nxt_out[0];
      port1_pin_out <= nxt_out[1];
      port5_pin_out <= nxt_out[2];
      port7_pin_out <= nxt_out[3];
      port0_pin_oe  <= nxt_oe[0];
      port1_pin_oe  <= nxt_oe[1];
      port5_pin_oe  <= nxt_oe[2];
      port7_pin_oe  <= nxt_oe[3];
      port0_pullup_en <= nxt_pu[0];
      port1_pullup_en <= nxt_pu[1];
      port5_pullup_en <= nxt_pu[2];
      port7_pullup_en <= nxt_pu[3];
      per_ff <= nxt_per;
      tev_ff <= nxt_tev;
    end
  end

  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign prdata        = prdata_ff;
  assign sio0_rxd      = per_ff[0];
  assign sio0_clk_in   = per_ff[1];
  assign sio1_rxd      = per_ff[2];
  assign sio1_clk_in   = per_ff[3];
  assign sio3_rxd      = per_ff[4];
  assign sio3_clk_in   = per_ff[5];
  assign sio4_data_in  = per_ff[6];
  assign sio4_clock_in = per_ff[7];
  assign timer_event   = tev_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    pready ##1 !pready;
  endsequence

  a_apb_ready_one: assert property (s_setup |=> s_access)
    else $error("ready did not follow setup for exactly one cycle");
  a_tx_serial_data: assert property ( // see R2
    md0_ff[0] && !md0_ff[3] && dir_ff[0][3] && !od_ff[0][3]
    |=> port0_pin_out[3] == $past(sio0_txd) && port0_pin_oe[3])
    else $error("sio0 transmit pin does not carry serial data");
  a_tx_uart_data: assert property ( // see R6
    md1_ff[0] && md1_ff[3] && dir_ff[0][0] && !od_ff[0][0]
    |=> port0_pin_out[0] == $past(uart1_txd))
    else $error("uart1 transmit pin does not carry uart data");
  a_gpio_idle_pin: assert property ( // see R3
    !md0_ff[0] && !od_ff[0][3]
    |=> port0_pin_out[3] == $past(dat_ff[0][3]) && port0_pin_oe[3] == $past(dir_ff[0][3]))
    else $error("idle serial pin does not follow port bits");
  a_rx_route_sync: assert property ( // see R4
    (md0_ff[1] && !dir_ff[0][4])[*3] |-> sio0_rxd == $past(port0_pin_in[4], 3))
    else $error("receive pin not delivered after two sync stages");
  a_open_drain_low: assert property ( // see R1
    od_ff[2][1] |=> !port5_pin_out[1] && (port5_pin_oe[1] -> !$past(val[2][1])))
    else $error("open-drain pin drove high");
  a_sio4_od_forced: assert property ( // see R8
    sio4_ff[0] && $past(sio4_ff[0]) |-> !port0_pin_out[1] && !port0_pin_out[2])
    else $error("interface 4 pin not open-drain");
  a_clk_master_drive: assert property ( // see R5
    md3_ff[0] && !md3_ff[3] && md3_ff[2] && dir_ff[2][2] && !od_ff[2][2]
    |=> port5_pin_oe[2] && port5_pin_out[2] == $past(sio3_clk_out))
    else $error("master clock not driven on clock pin");
  a_timer_evt_in: assert property ( // see R10
    (!dir_ff[1][2])[*3] |-> timer_event[2] == $past(port1_pin_in[2], 3))
    else $error("timer event input not routed");
  a_timer_out_sel: assert property ( // see R11
    p1sel_ff[3] && dir_ff[1][3] && !od_ff[1][3] |=> port1_pin_out[3] == $past(timer_out[3]))
    else $error("timer output not on pin");
  a_remote_carrier: assert property ( // see R14
    p1sel_ff[0] && dir_ff[1][0] && rm_ff[0] && !od_ff[1][0]
    |=> port1_pin_out[0] == ($past(timer_out[0]) & $past(remote_carrier)))
    else $error("remote pin does not carry modulated signal");
  a_pullup_input: assert property ( // see R12
    pu_ff[1][1] && !dir_ff[1][1] |=> port1_pullup_en[1])
    else $error("input pull-up not applied");

endmodule : stpm_top

//--- verif/stpm_sw_model.sv
// software-side apb master model that configures the pin multiplexer
`timescale 1ns/10ps
module stpm_sw_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
  end

  // request held until pready is sampled high; only the bench watchdog ends a dead wait
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    rd = 32'hXXXXXXXX;
    er = 1'bx;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // interface 4 only talks with its data and clock bits set to output
  task automatic sio4_setup(input logic [7:0] dir0);
    logic [31:0] rd;
    logic        er;
    xfer(1'b1, {4'h0, stpm_pkg::OFS_DIR}, {24'h0, dir0 | 8'h06}, rd, er);
    xfer(1'b1, {4'h0, stpm_pkg::OFS_SIO4CTL}, 32'h00000001, rd, er);
  endtask : sio4_setup
endmodule : stpm_sw_model

//--- verif/tb.sv
// self-checking bench for the serial/timer/remote pin multiplexer
`timescale 1ns/10ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0;
  wire  psel, penable, pwrite, pready, pslverr;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [7:0] port0_pin_in, port1_pin_in, port5_pin_in, port7_pin_in;
  wire [7:0] port0_pin_out, port1_pin_out, port5_pin_out, port7_pin_out;
  wire [7:0] port0_pin_oe, port1_pin_oe, port5_pin_oe, port7_pin_oe;
  wire [7:0] port0_pullup_en, port1_pullup_en, port5_pullup_en, port7_pullup_en;
  wire sio0_txd, uart0_txd, sio0_clk_out, sio1_txd, uart1_txd, sio1_clk_out;
  wire sio3_txd, sio3_clk_out, sio4_data_out, sio4_clock_out, remote_carrier;
  wire [3:0] timer_out, timer_event;
  wire sio0_rxd, sio0_clk_in, sio1_rxd, sio1_clk_in, sio3_rxd, sio3_clk_in;
  wire sio4_data_in, sio4_clock_in;
  wire [3:0][7:0] pout = {port7_pin_out, port5_pin_out, port1_pin_out, port0_pin_out};
  wire [3:0][7:0] poe = {port7_pin_oe, port5_pin_oe, port1_pin_oe, port0_pin_oe};
  wire [3:0][7:0] ppu = {port7_pullup_en, port5_pullup_en, port1_pullup_en, port0_pullup_en};
  wire [7:0] pin_rx = {sio4_clock_in, sio4_data_in, sio3_clk_in, sio3_rxd,
                       sio1_clk_in, sio1_rxd, sio0_clk_in, sio0_rxd};
  logic [3:0][7:0] ext, dir, pu, dat, od, eo, ee, odm, om, el;
  logic [14:0] pv;
  logic [7:0]  sel;
  logic [3:0]  m0, m1, m3, ev;
  logic        s4, rm;
  logic [31:0] rd;
  logic        er;
  int          seed, errors, compares;

  // the wire level: a driven pin shows the design's value, else the outside world
  assign {port7_pin_in, port5_pin_in, port1_pin_in, port0_pin_in} = (poe & pout) | (~poe & ext);
  assign {remote_carrier, timer_out, sio4_clock_out, sio4_data_out, sio3_clk_out, sio3_txd,
          sio1_clk_out, uart1_txd, sio1_txd, sio0_clk_out, uart0_txd, sio0_txd} = pv;

  stpm_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .port0_pin_in, .port1_pin_in, .port5_pin_in, .port7_pin_in, .port0_pin_out,
    .port1_pin_out, .port5_pin_out, .port7_pin_out, .port0_pin_oe, .port1_pin_oe, .port5_pin_oe,
    .port7_pin_oe, .port0_pullup_en, .port1_pullup_en, .port5_pullup_en, .port7_pullup_en,
    .sio0_txd, .uart0_txd, .sio0_clk_out, .sio1_txd, .uart1_txd, .sio1_clk_out, .sio3_txd,
    .sio3_clk_out, .sio4_data_out, .sio4_clock_out, .timer_out, .remote_carrier, .sio0_rxd,
    .sio0_clk_in, .sio1_rxd, .sio1_clk_in, .sio3_rxd, .sio3_clk_in, .sio4_data_in,
    .sio4_clock_in, .timer_event);
  stpm_sw_model SW (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr);

  always #2 pclk = ~pclk;

  task automatic final_report();
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    SW.xfer(1'b1, {4'h0, a}, {24'h0, v}, rd, er);
    SW.xfer(1'b0, {4'h0, a}, 32'h0, rd, er);
    chk(rd, {24'h0, v});
  endtask : wr

  // serial transmit and clock pin outputs of one interface
  task automatic ser(input int p, tx_b, ck_b, input logic [3:0] md, input logic tx, ut, ck);
    if (dir[p][tx_b] && md[stpm_pkg::MD_TX])
      eo[p][tx_b] = md[stpm_pkg::MD_UART] ? ut : tx;
    if ((md[0] | md[1]) && !md[3] && !(dir[p][ck_b] && md[stpm_pkg::MD_CLKMST]))
      ee[p][ck_b] = 1'b0;
    else if ((md[0] | md[1]) && !md[3])
      eo[p][ck_b] = ck;
  endtask : ser

  function automatic logic ckin(input logic [3:0] md, input int p, b);
    return (md[0] | md[1]) & ~md[3] & ~(dir[p][b] & md[2]) ? el[p][b] : 1'b1;
  endfunction : ckin

  task automatic check_pins();
    eo  = dat;
    ee  = dir;
    odm = od;
    ser(0, 3, 5, m0, pv[0], pv[1], pv[2]);
    ser(0, 0, 2, m1, pv[3], pv[4], pv[5]);
    ser(2, 1, 2, m3, pv[6], 1'b0, pv[7]);
    if (s4)
    begin
      eo[0][2:1] = pv[9:8];
      odm[0]     = odm[0] | 8'h06;
    end
    for (int t = 0; t < 4; t++)
      if (dir[1][t] && sel[t])
        eo[1][t] = (t == 0 && rm) ? pv[10] & pv[14] : pv[10+t];
    ee = ee & ~(odm & eo);
    eo = eo & ~odm;
    om = ee | odm;
    el = (ee & eo) | (~ee & ext);
    ev = ~dir[1][3:0] & el[1][3:0];
    chk(pout & om, eo & om);
    chk(poe, ee);
    chk(ppu & (~dir | ee), pu & ~dir);
    chk(timer_event, ev);
    chk(pin_rx, {s4 ? el[0][2:1] : 2'b11, ckin(m3, 2, 2), ~dir[2][0] & m3[1] ? el[2][0] : 1'b1,
                 ckin(m1, 0, 2), ~dir[0][1] & m1[1] ? el[0][1] : 1'b1,
                 ckin(m0, 0, 5), ~dir[0][4] & m0[1] ? el[0][4] : 1'b1});
    SW.xfer(1'b0, {4'h0, stpm_pkg::OFS_PINS}, 32'h0, rd, er);
    chk(rd, el);
  endtask : check_pins

  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    final_report();
  end

  initial
  begin
    seed = 32'he272;
    pv   = 15'h0000;
    ext  = 32'h00000000;
    repeat (2) @(posedge pclk);
    chk({poe, ppu}, 64'h0);
    chk(pout, 32'h0);
    chk({pready, pslverr, prdata}, 34'h0);
    chk({pin_rx, timer_event}, 32'h00000FF0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 8'h54; a += 4)
    begin
      SW.xfer(1'b0, 12'(a), 32'h0, rd, er);
      chk({er, rd}, 33'h0);
    end
    SW.xfer(1'b1, 12'h100, 32'h000000FF, rd, er);
    chk(er, 1'b1);
    SW.xfer(1'b0, 12'h05C, 32'h0, rd, er);
    chk({er, rd}, 33'h100000000);
    SW.xfer(1'b0, 12'h002, 32'h0, rd, er);
    chk(er, 1'b1);
    SW.xfer(1'b1, 12'h002, 32'h000000FF, rd, er);
    chk(er, 1'b1);
    SW.xfer(1'b0, 12'h000, 32'h0, rd, er);
    chk(rd, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge pclk);
      ext <= {$random(seed)};
      pv  <= 15'($random(seed));
      dir = {$random(seed)};
      pu  = {$random(seed)};
      dat = {$random(seed)};
      od  = {$random(seed)} & 32'h00060029;
      sel = 8'($random(seed)) & 8'h0F;
      m0  = 4'($random(seed));
      m1  = 4'($random(seed));
      m3  = 4'($random(seed)) & 4'h7;
      s4  = 1'($random(seed));
      rm  = 1'($random(seed));
      if (i == 0)
        {sel, m0, m1, m3, s4, rm} = 22'h0;
      if (i == 1)
      begin
        m0          = 4'hB;
        dir[0][4:3] = 2'b01;
      end
      if (i == 2)
        {sel[0], rm, dir[1][0]} = 3'b111;
      if (i == 3)
        s4 = 1'b1;
      if (s4)
      begin
        m1          = 4'h0;
        dir[0][2:1] = 2'b11;
      end
      for (int p = 0; p < 4; p++)
      begin
        wr(stpm_pkg::OFS_DIR + 8'(4 * p), dir[p]);
        wr(stpm_pkg::OFS_PU + 8'(4 * p), pu[p]);
        wr(stpm_pkg::OFS_DAT + 8'(4 * p), dat[p]);
        wr(stpm_pkg::OFS_OD + 8'(4 * p), od[p]);
      end
      wr(stpm_pkg::OFS_P1SEL, sel);
      wr(stpm_pkg::OFS_SIO0MD, {4'h0, m0});
      wr(stpm_pkg::OFS_SIO1MD, {4'h0, m1});
      wr(stpm_pkg::OFS_SIO3MD, {4'h0, m3});
      wr(stpm_pkg::OFS_RMCTL, {7'h00, rm});
      if (s4)
        SW.sio4_setup(dir[0]);
      else
        wr(stpm_pkg::OFS_SIO4CTL, 8'h00);
      repeat (6) @(posedge pclk);
      check_pins();
    end
    final_report();
  end
endmodule : tb
